/* File: src/mclk_cfg.svh */
`ifndef MCLK_CFG_SVH
`define MCLK_CFG_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define MCLK_OFS_MISC        8'hF0
`define MCLK_OFS_LEC         8'hF4
// ----------------------------------------
// misc register fields
// ----------------------------------------
`define MCLK_BIT_NO_ABORT    4
`define MCLK_BIT_ROUTE       3
`define MCLK_BIT_LINK_BYP    2
`define MCLK_BIT_HOST_BYP    1
`define MCLK_BIT_KEEP        0
`define MCLK_MISC_WMASK      32'h0000001F
`define MCLK_MISC_RESET      32'h00000000
// ----------------------------------------
// link enhancement register
// ----------------------------------------
`define MCLK_LEC_RESET       32'h00001000
`define MCLK_LEC_WMASK       32'h0000B582
// ----------------------------------------
// misc constants
// ----------------------------------------
`define MCLK_IDLE_READ       32'h000000FF
`define MCLK_ZERO32          32'h00000000
`define MCLK_ROM_CNT_W       3
`endif

/* File: src/mclk_pkg.sv */
package mclk_pkg;
  typedef struct packed {
    logic        no_abort_on_idle_link;
    logic        gpio_to_serial_rom_route;
    logic        link_clock_gate_bypass;
    logic        host_clock_gate_bypass;
    logic        keep_alive;
  } mclk_misc_type;

  typedef struct packed {
    logic        req;
    logic        wr;
    logic [7:0]  addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } mclk_cfg_req_type;

  typedef enum logic [2:0] {
    MCLK_ROM_IDLE = 3'h1,
    MCLK_ROM_LOAD = 3'h2,
    MCLK_ROM_DONE = 3'h4
  } mclk_rom_state_type;
endpackage : mclk_pkg

/* File: src/mclk_clk_gate.sv */
`timescale 1ns/1ns
// glitch-free enable gate with bypass; latch is transparent while clock is low
module mclk_clk_gate (
  input  wire logic clk_pin_in,    // raw clock from pin
  input  wire logic enable_in,     // normal gating enable
  input  wire logic bypass_in,     // test bypass
  output logic      clk_gated_out  // gated clock
);
  logic en_latch;
  always_latch begin
    if (!clk_pin_in) begin
      en_latch = enable_in | bypass_in;
    end
  end
  assign clk_gated_out = clk_pin_in & en_latch;
endmodule : mclk_clk_gate

/* File: src/mclk_regs.sv */
`timescale 1ns/1ns
`include "mclk_cfg.svh"
// Function
// - no-abort clear: access to idle link domain ends in target abort
// - no-abort set: idle-link access completes, reads return FFh
// - reroute set: gpio 3 drives serial clock, gpio 2 serial data
// - reroute set: gpio 3 and 2 output drivers released
// - link clock bypass makes internal link clock follow pin ungated
// - host clock bypass makes internal host clock follow pin ungated
// - keep-alive set: request host clock always running via clock-run
// - keep-alive clear: allow host clock stop via clock-run on pin six
// - misc control bits cleared only by global reset
// - enhancement bits loadable by software and by serial rom at init
// - enhancement bits effective only while phy enhance allow is set
// - enhancement register resets to 1000h, only listed bits writable
module mclk_regs (
  input  wire logic                     clk_in,            // host clock, 250 MHz
  input  wire logic                     arst_n_in,         // global reset, async low
  input  wire logic                     bus_reset_n_in,    // host bus reset, no effect here
  input  wire mclk_pkg::mclk_cfg_req_type cfg_in,          // config space request
  output logic [31:0]                   rdata_out,         // read data
  output logic                          ack_out,           // request completed
  output logic                          target_abort_out,  // abort of link access
  input  wire logic                     link_req_in,       // access to link-domain register
  input  wire logic                     link_active_in,    // link clock domain running
  input  wire logic [31:0]              link_rdata_in,     // data from active link domain
  input  wire logic                     phy_enhance_allow_in, // enable from host control
  output logic [31:0]                   lec_effective_out, // gated enhancement bits
  input  wire logic                     rom_valid_in,      // rom word for enhancement reg
  input  wire logic [31:0]              rom_data_in,       // rom load data
  input  wire logic                     rom_done_in,       // rom init finished
  input  wire logic [3:0]               gpio_in,           // general purpose inputs
  input  wire logic [3:0]               gpio_drive_in,     // wanted gpio output values
  input  wire logic [3:0]               gpio_dir_in,       // wanted gpio enables
  output logic [3:0]                    gpio_out,          // gpio output values
  output logic [3:0]                    gpio_oe_out,       // gpio output enables
  output logic                          rom_scl_out,       // internal serial clock line
  output logic                          rom_sda_out,       // internal serial data line
  input  wire logic                     link_clk_pin_in,   // link clock pin
  input  wire logic                     link_clk_en_in,    // link clock gating enable
  output logic                          link_clk_out,      // internal link clock
  input  wire logic                     host_clk_pin_in,   // host clock pin
  input  wire logic                     host_clk_en_in,    // host clock gating enable
  output logic                          host_clk_out,      // internal host clock
  input  wire logic                     clk_run_req_in,    // core wishes clock to keep
  output logic                          clkrun_o_out,      // pin six drive value
  output logic                          clkrun_oe_out      // pin six drive enable
);
  // ----------------------------------------
  // functions
  // ----------------------------------------
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  function automatic logic [31:0] bemask(input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      bemask[i*8 +: 8] = {8{be[i]}};
    end
  endfunction : bemask

  // ----------------------------------------
  // state
  // ----------------------------------------
  mclk_pkg::mclk_misc_type      misc_reg, misc_next;
  logic [31:0]                  lec_reg, lec_next;
  logic [31:0]                  rdata_next;
  logic                         ack_next, abort_next;
  logic [31:0]                  lec_eff_next;
  logic [3:0]                   gpo_reg, gpo_next, gpoe_reg, gpoe_next;
  logic                         scl_reg, scl_next, sda_reg, sda_next;
  logic                         crun_o_reg, crun_o_next, crun_oe_reg, crun_oe_next;
  mclk_pkg::mclk_rom_state_type rom_reg, rom_next;
  localparam logic [31:0]       MISC_RST = `MCLK_MISC_RESET;
  logic [31:0]                  misc_word;
  logic [31:0]                  misc_merge;
  logic [31:0]                  wmask;

  // host bus reset intentionally unused: bits here survive it
  logic unused_bus_reset;
  assign unused_bus_reset = bus_reset_n_in;

  assign misc_word = {27'h0000000, misc_reg};
  assign wmask     = bemask(cfg_in.be);
  // merged write word; only the low control bits survive into the register
  assign misc_merge = (misc_word & ~(wmask & `MCLK_MISC_WMASK)) |
                      (cfg_in.wdata & wmask & `MCLK_MISC_WMASK);

  // ----------------------------------------
  // rom loader
  // ----------------------------------------
  always_comb begin
    rom_next = rom_reg;
    case (rom_reg)
      mclk_pkg::MCLK_ROM_IDLE: rom_next = mclk_pkg::MCLK_ROM_LOAD;
      mclk_pkg::MCLK_ROM_LOAD: if (rom_done_in) rom_next = mclk_pkg::MCLK_ROM_DONE;
      mclk_pkg::MCLK_ROM_DONE: rom_next = mclk_pkg::MCLK_ROM_DONE;
      default:                 rom_next = mclk_pkg::MCLK_ROM_IDLE;
    endcase
  end

  // ----------------------------------------
  // register file
  // ----------------------------------------
  always_comb begin
    misc_next    = misc_reg;
    lec_next     = lec_reg;
    rdata_next   = `MCLK_ZERO32;
    ack_next     = 1'b0;
    abort_next   = 1'b0;
    if (rom_reg == mclk_pkg::MCLK_ROM_LOAD && rom_valid_in) begin
      lec_next = (lec_reg & ~`MCLK_LEC_WMASK) | (rom_data_in & `MCLK_LEC_WMASK);
    end
    if (cfg_in.req) begin
      if (link_req_in && !link_active_in) begin
        if (misc_reg.no_abort_on_idle_link) begin
          ack_next   = 1'b1;
          rdata_next = cfg_in.wr ? `MCLK_ZERO32 : `MCLK_IDLE_READ;
        end else begin
          abort_next = 1'b1;
        end
      end else if (link_req_in) begin
        ack_next   = 1'b1;
        rdata_next = cfg_in.wr ? `MCLK_ZERO32 : link_rdata_in;
      end else if (hit(cfg_in.addr, `MCLK_OFS_MISC)) begin
        ack_next = 1'b1;
        if (cfg_in.wr) begin
          misc_next = mclk_pkg::mclk_misc_type'(misc_merge[`MCLK_BIT_NO_ABORT:0]);
        end else begin
          rdata_next = misc_word;
        end
      end else if (hit(cfg_in.addr, `MCLK_OFS_LEC)) begin
        ack_next = 1'b1;
        if (cfg_in.wr) begin
          lec_next = (lec_reg & ~(wmask & `MCLK_LEC_WMASK)) |
                     (cfg_in.wdata & wmask & `MCLK_LEC_WMASK);
        end else begin
          rdata_next = lec_reg;
        end
      end else begin
        ack_next = 1'b1;
      end
    end
  end

  // ----------------------------------------
  // pins and clock control
  // ----------------------------------------
  always_comb begin
    lec_eff_next = phy_enhance_allow_in ? lec_reg : `MCLK_ZERO32;
    gpo_next     = gpio_drive_in;
    gpoe_next    = gpio_dir_in;
    scl_next     = 1'b1;
    sda_next     = 1'b1;
    if (misc_reg.gpio_to_serial_rom_route) begin
      scl_next       = gpio_in[3];
      sda_next       = gpio_in[2];
      gpoe_next[3:2] = 2'h0;
    end
    // clock-run is open drain low; drive low to ask for the clock
    crun_o_next  = 1'b0;
    crun_oe_next = misc_reg.keep_alive | clk_run_req_in;
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      misc_reg    <= mclk_pkg::mclk_misc_type'(MISC_RST[`MCLK_BIT_NO_ABORT:0]);
      lec_reg     <= `MCLK_LEC_RESET;
      rdata_out   <= `MCLK_ZERO32;
      ack_out     <= 1'b0;
      target_abort_out <= 1'b0;
      lec_effective_out <= `MCLK_ZERO32;
      gpo_reg     <= 4'h0;
      gpoe_reg    <= 4'h0;
      scl_reg     <= 1'b1;
      sda_reg     <= 1'b1;
      crun_o_reg  <= 1'b0;
      crun_oe_reg <= 1'b0;
      rom_reg     <= mclk_pkg::MCLK_ROM_IDLE;
    end else begin
      misc_reg    <= misc_next;
      lec_reg     <= lec_next;
      rdata_out   <= rdata_next;
      ack_out     <= ack_next;
      target_abort_out <= abort_next;
      lec_effective_out <= lec_eff_next;
      gpo_reg     <= gpo_next;
      gpoe_reg    <= gpoe_next;
      scl_reg     <= scl_next;
      sda_reg     <= sda_next;
      crun_o_reg  <= crun_o_next;
      crun_oe_reg <= crun_oe_next;
      rom_reg     <= rom_next;
    end
  end

  assign gpio_out      = gpo_reg;
  assign gpio_oe_out   = gpoe_reg;
  assign rom_scl_out   = scl_reg;
  assign rom_sda_out   = sda_reg;
  assign clkrun_o_out  = crun_o_reg;
  assign clkrun_oe_out = crun_oe_reg;

  // ----------------------------------------
  // clock gating; outputs are clocks, not flops, by nature
  // ----------------------------------------
  mclk_clk_gate u_link_gate (
    .clk_pin_in    (link_clk_pin_in),
    .enable_in     (link_clk_en_in),
    .bypass_in     (misc_reg.link_clock_gate_bypass),
    .clk_gated_out (link_clk_out)
  );
  mclk_clk_gate u_host_gate (
    .clk_pin_in    (host_clk_pin_in),
    .enable_in     (host_clk_en_in),
    .bypass_in     (misc_reg.host_clock_gate_bypass),
    .clk_gated_out (host_clk_out)
  );

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  sequence s_idle_link_req;
    cfg_in.req && link_req_in && !link_active_in;
  endsequence

  a_abort_when_idle: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    s_idle_link_req and !misc_reg.no_abort_on_idle_link |=> target_abort_out && !ack_out)
    else $error("idle link access not aborted");
  a_ff_when_noabort: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    s_idle_link_req and misc_reg.no_abort_on_idle_link and !cfg_in.wr
      |=> ack_out && !target_abort_out && rdata_out == `MCLK_IDLE_READ)
    else $error("idle link read did not return FFh");
  a_route_scl_sda: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    misc_reg.gpio_to_serial_rom_route && $stable(misc_reg)
      |=> rom_scl_out == $past(gpio_in[3]) && rom_sda_out == $past(gpio_in[2]))
    else $error("serial lines not fed from gpio");
  a_route_hiz: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    misc_reg.gpio_to_serial_rom_route |=> gpio_oe_out[3:2] == 2'h0)
    else $error("gpio 3/2 driven while rerouted");
  a_keep_clock: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    misc_reg.keep_alive |=> clkrun_oe_out && !clkrun_o_out)
    else $error("clock-run not held while keep-alive set");
  a_allow_stop: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    !misc_reg.keep_alive && !clk_run_req_in |=> !clkrun_oe_out)
    else $error("clock-run driven with keep-alive clear");
  a_enh_gated: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    !phy_enhance_allow_in |=> lec_effective_out == `MCLK_ZERO32)
    else $error("enhancement bits effective without allow");
  a_lec_ro_bits: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (lec_reg & ~`MCLK_LEC_WMASK) == (`MCLK_LEC_RESET & ~`MCLK_LEC_WMASK))
    else $error("read-only enhancement bit changed");
  a_misc_hold: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    !(cfg_in.req && cfg_in.wr && hit(cfg_in.addr, `MCLK_OFS_MISC)) |=> $stable(misc_reg))
    else $error("misc bits changed without a write");
  a_lec_rom_load: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    rom_reg == mclk_pkg::MCLK_ROM_LOAD && rom_valid_in && !cfg_in.req
      |=> (lec_reg & `MCLK_LEC_WMASK) == ($past(rom_data_in) & `MCLK_LEC_WMASK))
    else $error("rom load of enhancement register lost");
endmodule : mclk_regs

/* File: verif/mclk_host.sv */
`timescale 1ns/1ns
// ----------------------------------------
// host side of configuration space
// ----------------------------------------
module mclk_host (
  input  wire logic                  clk_in,       // host clock
  output mclk_pkg::mclk_cfg_req_type cfg_out,      // request to device
  output logic                       link_req_out, // request aims at link domain
  input  wire logic [31:0]           rdata_in,     // read data
  input  wire logic                  ack_in,       // completion
  input  wire logic                  abort_in      // target abort
);
  initial begin
    cfg_out      = '0;
    link_req_out = 1'b0;
  end

  // one pulse per access; the answer stands only in the cycle after the taking edge
  task automatic access(input logic wr, input logic [7:0] a, input logic [3:0] be,
                        input logic [31:0] wd, input logic lk,
                        output logic [31:0] rd, output logic ak, output logic ab);
    @(posedge clk_in);
    #1;
    cfg_out      = '{req: 1'b1, wr: wr, addr: a, be: be, wdata: wd};
    link_req_out = lk;
    @(posedge clk_in);
    #1;
    // the answer launched by the taking edge is gone after the next edge
    rd = rdata_in;
    ak = ack_in;
    ab = abort_in;
    // released lines carry the inverse so stale values cannot look valid
    cfg_out      = '{req: 1'b0, wr: ~wr, addr: ~a, be: ~be, wdata: ~wd};
    link_req_out = 1'b0;
  endtask : access
endmodule : mclk_host

/* File: verif/tb_top.sv */
`timescale 1ns/1ns
`include "mclk_cfg.svh"
module tb_top;
  localparam int          TCK = 4;
  localparam logic [31:0] WM  = `MCLK_LEC_WMASK;
  logic        clk_in = 1'b0, arst_n_in = 1'b0, bus_reset_n_in = 1'b0;
  mclk_pkg::mclk_cfg_req_type cfg_in;
  logic        link_req_in, ack_out, target_abort_out, ak, ab;
  logic        link_active_in = 1'b0, phy_enhance_allow_in = 1'b0;
  logic        rom_valid_in = 1'b0, rom_done_in = 1'b0, clk_run_req_in = 1'b0;
  logic [31:0] link_rdata_in = 32'h0, rom_data_in = 32'h0, rdata_out, lec_effective_out, rd, v;
  logic [3:0]  gpio_in = 4'h0, gpio_drive_in = 4'h0, gpio_dir_in = 4'hF, gpio_out, gpio_oe_out, be_v;
  logic        rom_scl_out, rom_sda_out, link_clk_out, host_clk_out, clkrun_o_out, clkrun_oe_out;
  logic        link_clk_pin_in = 1'b0, link_clk_en_in = 1'b0;
  logic        host_clk_pin_in = 1'b0, host_clk_en_in = 1'b0;
  logic [15:0] lfsr = 16'h0032;
  int          bad_count = 0, checks_done = 0, lec_m = `MCLK_LEC_RESET;

  always #(TCK / 2) clk_in = ~clk_in;

  mclk_host host (.clk_in, .cfg_out(cfg_in), .link_req_out(link_req_in), .rdata_in(rdata_out),
                  .ack_in(ack_out), .abort_in(target_abort_out));
  mclk_regs dut (.clk_in, .arst_n_in, .bus_reset_n_in, .cfg_in, .rdata_out, .ack_out,
                 .target_abort_out, .link_req_in, .link_active_in, .link_rdata_in,
                 .phy_enhance_allow_in, .lec_effective_out, .rom_valid_in, .rom_data_in,
                 .rom_done_in, .gpio_in, .gpio_drive_in, .gpio_dir_in, .gpio_out, .gpio_oe_out,
                 .rom_scl_out, .rom_sda_out, .link_clk_pin_in, .link_clk_en_in, .link_clk_out,
                 .host_clk_pin_in, .host_clk_en_in, .host_clk_out, .clk_run_req_in,
                 .clkrun_o_out, .clkrun_oe_out);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    v    = {~lfsr, lfsr};
  endtask : rnd

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : cyc

  task automatic rw(input logic wr, input logic [7:0] a, input logic [3:0] be,
                    input logic [31:0] wd, input logic lk);
    host.access(wr, a, be, wd, lk, rd, ak, ab);
  endtask : rw

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    rw(1'b0, a, 4'hF, 32'h0, 1'b0);
    chk({ab, ak}, 2'b01);
    chk(rd, exp);
  endtask : rchk

  task automatic wmisc(input logic [31:0] wd);
    rw(1'b1, `MCLK_OFS_MISC, 4'hF, wd, 1'b0);
    chk({ab, ak}, 2'b01);
  endtask : wmisc

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_sim

  // ----------------------------------------
  // watchdog: the sequence needs well under 1000 cycles
  // ----------------------------------------
  initial begin
    #(20000 * TCK);
    bad_count++;
    end_sim();
  end

  initial begin
    cyc(12);
    arst_n_in      = 1'b1;
    bus_reset_n_in = 1'b1;
    cyc(1);
    rnd();
    rom_data_in  = v;
    rom_valid_in = 1'b1;
    cyc(1);
    lec_m        = (v & WM) | (`MCLK_LEC_RESET & ~WM);
    rom_valid_in = 1'b0;
    rom_done_in  = 1'b1;
    rom_data_in  = ~v;
    cyc(1);
    rom_valid_in = 1'b1;
    cyc(1);
    rom_valid_in = 1'b0;
    rchk(`MCLK_OFS_LEC, lec_m);
    rchk(`MCLK_OFS_MISC, `MCLK_MISC_RESET);
    rchk(8'h80, `MCLK_ZERO32);
    $display("test rom load done");
    for (int i = 0; i < 8; i++) begin
      rnd();
      be_v = (i == 0) ? 4'hF : v[7:4];
      rw(1'b1, `MCLK_OFS_LEC, be_v, v, 1'b0);
      for (int b = 0; b < 4; b++) begin
        if (be_v[b]) lec_m[8*b+:8] = (lec_m[8*b+:8] & ~WM[8*b+:8]) | (v[8*b+:8] & WM[8*b+:8]);
      end
      rchk(`MCLK_OFS_LEC, lec_m);
      phy_enhance_allow_in = i[0];
      cyc(2);
      chk(lec_effective_out, i[0] ? lec_m : 0);
    end
    $display("test enhancement register done");
    wmisc(32'hFFFFFFFF);
    rchk(`MCLK_OFS_MISC, `MCLK_MISC_WMASK);
    for (int r = 0; r < 2; r++) begin
      rnd();
      gpio_in     = v[3:0];
      gpio_dir_in = v[7:4];
      gpio_drive_in = v[11:8];
      cyc(2);
      chk(gpio_out, gpio_drive_in);
      chk({rom_scl_out, rom_sda_out}, r ? 2'b11 : gpio_in[3:2]);
      chk(gpio_oe_out, r ? gpio_dir_in : {2'b00, gpio_dir_in[1:0]});
      chk({clkrun_oe_out, clkrun_o_out}, r ? 2'b00 : 2'b10);
      wmisc(32'h0);
    end
    clk_run_req_in = 1'b1;
    cyc(2);
    chk({clkrun_oe_out, clkrun_o_out}, 2'b10);
    $display("test route and keep alive done");
    for (int b = 0; b < 2; b++) begin
      wmisc(b ? 32'h6 : 32'h0);
      {link_clk_pin_in, host_clk_pin_in} = 2'b11;
      cyc(1);
      chk({link_clk_out, host_clk_out}, b ? 2'b11 : 2'b00);
      {link_clk_pin_in, host_clk_pin_in} = 2'b00;
    end
    wmisc(32'h0);
    $display("test clock bypass done");
    rnd();
    link_rdata_in = v;
    rw(1'b0, 8'h10, 4'hF, 32'h0, 1'b1);
    chk({ab, ak}, 2'b10);
    wmisc(32'h10);
    rw(1'b0, 8'h10, 4'hF, 32'h0, 1'b1);
    chk({ab, ak}, 2'b01);
    chk(rd, `MCLK_IDLE_READ);
    rw(1'b1, 8'h10, 4'hF, v, 1'b1);
    chk({ab, ak}, 2'b01);
    wmisc(32'h0);
    link_active_in = 1'b1;
    rw(1'b0, 8'h10, 4'hF, 32'h0, 1'b1);
    chk({ab, ak}, 2'b01);
    chk(rd, link_rdata_in);
    $display("test link abort done");
    wmisc(32'h1F);
    bus_reset_n_in = 1'b0;
    cyc(3);
    bus_reset_n_in = 1'b1;
    rchk(`MCLK_OFS_MISC, 32'h1F);
    arst_n_in = 1'b0;
    cyc(2);
    arst_n_in = 1'b1;
    cyc(2);
    rchk(`MCLK_OFS_MISC, `MCLK_MISC_RESET);
    rchk(`MCLK_OFS_LEC, `MCLK_LEC_RESET);
    $display("test resets done");
    end_sim();
  end
endmodule : tb_top
